// File: hdl/cafl_filter.sv
// Receive acceptance filter with two-entry output buffer and retry policy
`timescale 1ns/10ps
`default_nettype none
module cafl_filter
    import cafl_pkg::*;
(
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_COMM_RUN,
    input  wire logic        I_CFG_WE,
    input  wire logic [1:0]  I_CFG_MODE,
    input  wire logic [31:0] I_CFG_MASK,
    input  wire logic [31:0] I_CFG_CMP,
    input  wire logic        I_CFG_SSHOT,
    output logic      [1:0]  O_MODE,
    output logic             O_SSHOT,
    input  wire logic        I_RX_VALID,
    output logic             O_RX_READY,
    input  wire logic        I_RX_IDE,
    input  wire logic        I_RX_RTR,
    input  wire logic [28:0] I_RX_ID,
    input  wire logic [3:0]  I_RX_DLC,
    input  wire logic [7:0]  I_RX_D0,
    input  wire logic [7:0]  I_RX_D1,
    output logic             O_ACC_VALID,
    input  wire logic        I_ACC_READY,
    output logic             O_ACC_IDE,
    output logic             O_ACC_RTR,
    output logic      [28:0] O_ACC_ID,
    output logic      [3:0]  O_ACC_DLC,
    output logic      [7:0]  O_ACC_D0,
    output logic      [7:0]  O_ACC_D1,
    input  wire logic        I_TX_FAIL,
    output logic             O_TX_RETRY,
    output logic             O_TX_ABORT
);

    // ==========================================================
    // Match helper
    // ==========================================================
    // Every pattern bit that is cared about must equal, or be masked
    function automatic logic fmatch(input logic [31:0] pat,
                                    input logic [31:0] care,
                                    input logic [31:0] cmp,
                                    input logic [31:0] mask);
        fmatch = &((~(pat ^ cmp)) | mask | ~care);
    endfunction : fmatch

    // ==========================================================
    // Configuration
    // ==========================================================
    cafl_mode_t  mode;
    logic [31:0] mask;
    logic [31:0] cmp;
    logic        sshot;

    // Writes while running are dropped so a frame never sees half a setup
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            mode  <= MODE_RST;
            mask  <= MASK_RST;
            cmp   <= CMP_RST;
            sshot <= SSHOT_RST;
        end else if (I_CFG_WE && !I_COMM_RUN) begin
            mode  <= cafl_mode_t'(I_CFG_MODE);
            mask  <= I_CFG_MASK;
            cmp   <= I_CFG_CMP;
            sshot <= I_CFG_SSHOT;
        end
    end

    // Config readback
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_MODE  <= MODE_RST;
            O_SSHOT <= SSHOT_RST;
        end else begin
            O_MODE  <= mode;
            O_SSHOT <= sshot;
        end
    end

    // ==========================================================
    // Pattern building and decision
    // ==========================================================
    logic [31:0] pat_a;
    logic [31:0] care_a;
    logic [31:0] pat_b;
    logic [31:0] care_b;
    logic        has_d0;
    logic        has_d1;
    logic        hit_a;
    logic        hit_b;
    logic        hit;

    // Absent data bytes never block a match; remote frames carry none
    assign has_d0 = !I_RX_RTR && (I_RX_DLC != 4'h0);
    assign has_d1 = !I_RX_RTR && (I_RX_DLC > 4'h1);

    // Reserved positions are never cared about, whatever software wrote
    always_comb begin
        pat_a  = 32'h00000000;
        care_a = 32'h00000000;
        pat_b  = 32'h00000000;
        care_b = 32'h00000000;
        case (mode)
            CAFL_SINGLE_STD: begin
                pat_a[SSTD_ID_POS +: 11]  = I_RX_ID[10:0];
                pat_a[SSTD_RTR_POS]       = I_RX_RTR;
                pat_a[SSTD_D0_POS +: 8]   = I_RX_D0;
                pat_a[SSTD_D1_POS +: 8]   = I_RX_D1;
                care_a[SSTD_ID_POS +: 11] = 11'h7FF;
                care_a[SSTD_RTR_POS]      = 1'h1;
                care_a[SSTD_D0_POS +: 8]  = {8{has_d0}};
                care_a[SSTD_D1_POS +: 8]  = {8{has_d1}};
            end
            CAFL_SINGLE_EXT: begin
                pat_a[SEXT_ID_POS +: 29]  = I_RX_ID;
                pat_a[SEXT_RTR_POS]       = I_RX_RTR;
                care_a[SEXT_ID_POS +: 29] = 29'h1FFFFFFF;
                care_a[SEXT_RTR_POS]      = 1'h1;
            end
            CAFL_DUAL_STD: begin
                pat_a[DSTD1_ID_POS +: 11]  = I_RX_ID[10:0];
                pat_a[DSTD1_RTR_POS]       = I_RX_RTR;
                pat_a[DSTD1_DH_POS +: 4]   = I_RX_D0[7:4];
                pat_a[DSTD1_DL_POS +: 4]   = I_RX_D0[3:0];
                care_a[DSTD1_ID_POS +: 11] = 11'h7FF;
                care_a[DSTD1_RTR_POS]      = 1'h1;
                care_a[DSTD1_DH_POS +: 4]  = {4{has_d0}};
                care_a[DSTD1_DL_POS +: 4]  = {4{has_d0}};
                pat_b[DSTD2_ID_POS +: 11]  = I_RX_ID[10:0];
                pat_b[DSTD2_RTR_POS]       = I_RX_RTR;
                care_b[DSTD2_ID_POS +: 11] = 11'h7FF;
                care_b[DSTD2_RTR_POS]      = 1'h1;
            end
            CAFL_DUAL_EXT: begin
                pat_a[DEXT1_ID_POS +: 16]  = I_RX_ID[EXT_UP16_POS +: 16];
                pat_b[DEXT2_ID_POS +: 16]  = I_RX_ID[EXT_UP16_POS +: 16];
                care_a[DEXT1_ID_POS +: 16] = 16'hFFFF;
                care_b[DEXT2_ID_POS +: 16] = 16'hFFFF;
            end
            default: pat_a = 32'h00000000;
        endcase
    end

    assign hit_a = fmatch(pat_a, care_a, cmp, mask);
    assign hit_b = fmatch(pat_b, care_b, cmp, mask);

    // Frames of the other identifier format are discarded in every mode
    always_comb begin
        case (mode)
            CAFL_SINGLE_STD: hit = !I_RX_IDE && hit_a;
            CAFL_SINGLE_EXT: hit = I_RX_IDE && hit_a;
            CAFL_DUAL_STD:   hit = !I_RX_IDE && (hit_a || hit_b);
            CAFL_DUAL_EXT:   hit = I_RX_IDE && (hit_a || hit_b);
            default:         hit = 1'h0;
        endcase
    end

    // ==========================================================
    // Two-entry output buffer
    // ==========================================================
    logic        rx_fire;
    logic        push;
    logic        pop;
    logic [1:0]  cnt;
    logic [1:0]  next_cnt;
    logic        e1_ide;
    logic        e1_rtr;
    logic [28:0] e1_id;
    logic [3:0]  e1_dlc;
    logic [7:0]  e1_d0;
    logic [7:0]  e1_d1;
    logic        head_from_e1;
    logic        head_from_in;
    logic        e1_load;

    assign rx_fire  = I_RX_VALID && O_RX_READY;
    assign push     = rx_fire && hit;
    assign pop      = O_ACC_VALID && I_ACC_READY;
    assign next_cnt = 2'(cnt + {1'h0, push} - {1'h0, pop});
    assign head_from_e1 = pop && (cnt == BUF_DEPTH);
    assign head_from_in = push && ((cnt == 2'h0) || (pop && cnt == 2'h1));
    assign e1_load = push && ((cnt == 2'h1 && !pop) ||
                              (cnt == BUF_DEPTH && pop));

    // Occupancy and handshake flags; ready is held low when full
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            cnt         <= 2'h0;
            O_ACC_VALID <= 1'h0;
            O_RX_READY  <= 1'h0;
        end else begin
            cnt         <= next_cnt;
            O_ACC_VALID <= (next_cnt != 2'h0);
            O_RX_READY  <= (next_cnt != BUF_DEPTH);
        end
    end

    // Head entry drives the outputs directly from flops
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            {O_ACC_IDE, O_ACC_RTR, O_ACC_ID} <= 31'h00000000;
            {O_ACC_DLC, O_ACC_D0, O_ACC_D1}  <= 20'h00000;
        end else if (head_from_e1) begin
            {O_ACC_IDE, O_ACC_RTR, O_ACC_ID} <= {e1_ide, e1_rtr, e1_id};
            {O_ACC_DLC, O_ACC_D0, O_ACC_D1}  <= {e1_dlc, e1_d0, e1_d1};
        end else if (head_from_in) begin
            {O_ACC_IDE, O_ACC_RTR, O_ACC_ID} <= {I_RX_IDE, I_RX_RTR, I_RX_ID};
            {O_ACC_DLC, O_ACC_D0, O_ACC_D1}  <= {I_RX_DLC, I_RX_D0, I_RX_D1};
        end
    end

    // Second entry catches a frame while the consumer stalls
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            {e1_ide, e1_rtr, e1_id}  <= 31'h00000000;
            {e1_dlc, e1_d0, e1_d1}   <= 20'h00000;
        end else if (e1_load) begin
            {e1_ide, e1_rtr, e1_id}  <= {I_RX_IDE, I_RX_RTR, I_RX_ID};
            {e1_dlc, e1_d0, e1_d1}   <= {I_RX_DLC, I_RX_D0, I_RX_D1};
        end
    end

    // ==========================================================
    // Transmit retry policy
    // ==========================================================
    // One-cycle answer to each failed attempt: retry or give up
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            O_TX_RETRY <= 1'h0;
            O_TX_ABORT <= 1'h0;
        end else begin
            O_TX_RETRY <= I_TX_FAIL && !sshot;
            O_TX_ABORT <= I_TX_FAIL && sshot;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_fail_multi;
        I_TX_FAIL && !sshot;
    endsequence
    sequence s_fail_single;
        I_TX_FAIL && sshot;
    endsequence

    a_retry_next: assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_fail_multi |=> O_TX_RETRY && !O_TX_ABORT)
        else $error("retry not raised after failed attempt");
    a_single_noretry: assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_fail_single |=> O_TX_ABORT && !O_TX_RETRY)
        else $error("single-shot frame was retried");
    a_cfg_frozen: assert property (@(posedge I_MCLK) disable iff (I_RST)
        I_COMM_RUN |=> $stable(mode) && $stable(mask) && $stable(sshot))
        else $error("configuration changed while running");
    a_reject_drop: assert property (@(posedge I_MCLK) disable iff (I_RST)
        rx_fire && !hit && !pop |=> cnt == $past(cnt))
        else $error("rejected frame entered buffer");
    a_accept_push: assert property (@(posedge I_MCLK) disable iff (I_RST)
        rx_fire && hit && !pop |=> cnt == $past(cnt) + 2'h1)
        else $error("accepted frame not buffered");
    a_dual_either: assert property (@(posedge I_MCLK) disable iff (I_RST)
        mode == CAFL_DUAL_EXT && I_RX_IDE && (hit_a || hit_b) |-> hit)
        else $error("dual filter did not accept on one match");
    a_allpass_mask: assert property (@(posedge I_MCLK) disable iff (I_RST)
        mask == 32'hFFFFFFFF && (mode == CAFL_SINGLE_EXT) == I_RX_IDE
        && mode[0] == 1'h0 |-> hit)
        else $error("all-ones mask rejected a frame");
    a_ext_upper: assert property (@(posedge I_MCLK) disable iff (I_RST)
        mode == CAFL_DUAL_EXT |-> care_a == 32'hFFFF0000
        && care_b == 32'h0000FFFF)
        else $error("dual extended compares wrong bits");
    // Ready still shows its reset level at the first edge after release
    a_valid_count: assert property (@(posedge I_MCLK) disable iff (I_RST)
        O_ACC_VALID == (cnt != 2'h0)
        && ($past(I_RST) || O_RX_READY == (cnt != BUF_DEPTH)))
        else $error("buffer flags disagree with occupancy");

endmodule : cafl_filter
`default_nettype wire

// File: hdl/cafl_pkg.sv
// Shared constants and types for the CAN acceptance filter block
package cafl_pkg;

    // ==========================================================
    // Filter modes
    // ==========================================================
    typedef enum logic [1:0] {
        CAFL_SINGLE_STD = 2'h0,
        CAFL_SINGLE_EXT = 2'h1,
        CAFL_DUAL_STD   = 2'h2,
        CAFL_DUAL_EXT   = 2'h3
    } cafl_mode_t;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam cafl_mode_t  MODE_RST   = CAFL_SINGLE_STD;
    localparam logic [31:0] MASK_RST   = 32'hFFFFFFFF;
    localparam logic [31:0] CMP_RST    = 32'h00000000;
    localparam logic        SSHOT_RST  = 1'h0;

    // ==========================================================
    // Pattern field positions (lowest bit of each field)
    // ==========================================================
    localparam int SSTD_ID_POS  = 21;
    localparam int SSTD_RTR_POS = 20;
    localparam int SSTD_D0_POS  = 8;
    localparam int SSTD_D1_POS  = 0;
    localparam int SEXT_ID_POS  = 3;
    localparam int SEXT_RTR_POS = 2;
    localparam int DSTD1_ID_POS = 21;
    localparam int DSTD1_RTR_POS = 20;
    localparam int DSTD1_DH_POS = 16;
    localparam int DSTD1_DL_POS = 0;
    localparam int DSTD2_ID_POS = 5;
    localparam int DSTD2_RTR_POS = 4;
    localparam int DEXT1_ID_POS = 16;
    localparam int DEXT2_ID_POS = 0;
    localparam int EXT_UP16_POS = 13;

    // ==========================================================
    // Buffer
    // ==========================================================
    localparam logic [1:0] BUF_DEPTH = 2'h2;

endpackage : cafl_pkg

// File: dv/cafl_can_node.sv
// Bus side model: supplies received CAN frames over valid/ready
`timescale 1ns/10ps
`default_nettype none
module cafl_can_node (
    input  wire logic        i_mclk,
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic      [50:0] o_frame
);
    logic [50:0] q[$];
    logic        took;

    // Frames wait here until the filter takes them, one per handshake
    task automatic push(input logic [50:0] f);
        q.push_back(f);
    endtask : push

    initial begin
        o_valid = 1'b0;
        o_frame = '0;
        took    = 1'b0;
    end

    // Handshake is judged on the rising edge only
    always @(posedge i_mclk) begin
        took <= o_valid & i_ready;
    end

    // Lines move after the falling edge; idle frame lines toggle, never hold, while valid holds low
    always @(negedge i_mclk) begin
        if (took && q.size() > 0) begin
            void'(q.pop_front());
        end
        o_valid = (q.size() > 0);
        o_frame = (q.size() > 0) ? q[0] : ~o_frame;
    end
endmodule : cafl_can_node
`default_nettype wire

// File: dv/can_acceptance_filter_tb.sv
// Self-checking bench for the CAN acceptance filter
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("CHECK FAILED at %0t: got %0h expected %0h", \
    $time, (g), (e)); end end
module can_acceptance_filter_tb;
    import cafl_pkg::*;
    logic        mclk = 0, rst = 1, run = 0, we = 0, sshot = 0, fail = 0;
    logic [1:0]  mode = 0, o_mode;
    logic [31:0] mask = 0, cmp = 0;
    logic        rx_valid, rx_ready, acc_valid, acc_ready = 1;
    logic        acc_ide, acc_rtr, o_sshot, retry, abort;
    logic [50:0] rx_f;
    logic [28:0] acc_id;
    logic [3:0]  acc_dlc;
    logic [7:0]  acc_d0, acc_d1;
    logic [50:0] got[$], exp[$];
    int          num_errors = 0, comparisons = 0;

    // ==========================================================
    // Clock, parts and monitor
    // ==========================================================
    always #4 mclk = ~mclk;
    cafl_can_node node (.i_mclk(mclk), .i_ready(rx_ready),
        .o_valid(rx_valid), .o_frame(rx_f));
    cafl_filter uut (.I_MCLK(mclk), .I_RST(rst), .I_COMM_RUN(run),
        .I_CFG_WE(we), .I_CFG_MODE(mode), .I_CFG_MASK(mask),
        .I_CFG_CMP(cmp), .I_CFG_SSHOT(sshot), .O_MODE(o_mode),
        .O_SSHOT(o_sshot), .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready),
        .I_RX_IDE(rx_f[50]), .I_RX_RTR(rx_f[49]), .I_RX_ID(rx_f[48:20]),
        .I_RX_DLC(rx_f[19:16]), .I_RX_D0(rx_f[15:8]), .I_RX_D1(rx_f[7:0]),
        .O_ACC_VALID(acc_valid), .I_ACC_READY(acc_ready),
        .O_ACC_IDE(acc_ide), .O_ACC_RTR(acc_rtr), .O_ACC_ID(acc_id),
        .O_ACC_DLC(acc_dlc), .O_ACC_D0(acc_d0), .O_ACC_D1(acc_d1),
        .I_TX_FAIL(fail), .O_TX_RETRY(retry), .O_TX_ABORT(abort));
    // Every frame handed to the consumer is logged in arrival order
    always @(posedge mclk) begin
        if (acc_valid === 1'b1 && acc_ready === 1'b1) begin
            got.push_back({acc_ide, acc_rtr, acc_id, acc_dlc, acc_d0, acc_d1});
        end
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    function automatic logic [50:0] fr(input logic e, r,
        input logic [28:0] id, input logic [7:0] d0, d1);
        return {e, r, id, 4'h8, d0, d1};
    endfunction : fr
    task automatic snd(input logic [50:0] f, input bit a);
        node.push(f);
        if (a) exp.push_back(f);
    endtask : snd
    // Waits for the source to run dry, then compares what came out
    task automatic drain();
        int n;
        logic [50:0] a, b;
        n = 0;
        while ((node.q.size() != 0 || rx_valid) && n < 200) begin
            @(negedge mclk);
            n++;
        end
        repeat (6) @(negedge mclk);
        `CHK(got.size(), exp.size())
        while (got.size() > 0 && exp.size() > 0) begin
            a = got.pop_front();
            b = exp.pop_front();
            `CHK(a, b)
        end
        got.delete();
        exp.delete();
    endtask : drain
    // Loads a configuration with communication stopped
    task automatic cfg(input logic [1:0] m, input logic [31:0] mk, cm,
        input logic ss);
        @(negedge mclk);
        run = 1'b0;
        {we, mode, mask, cmp, sshot} = {1'b1, m, mk, cm, ss};
        @(negedge mclk);
        we = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK(o_mode, m)
        `CHK(o_sshot, ss)
        run = 1'b1;
    endtask : cfg
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_defaults();
        `CHK(o_mode, 2'h0)
        `CHK(o_sshot, 1'h0)
        run = 1'b1;
        snd(fr(0, 1, 29'h7FF, 8'hA5, 8'h5A), 1);
        snd(fr(1, 0, 29'h1FFFFFFF, 8'h00, 8'h01), 0);
        drain();
    endtask : t_defaults
    task automatic t_sstd();
        cfg(2'h0, 32'h000000FF, {11'h5A3, 1'b0, 4'h0, 8'hC4, 8'h3B}, 0);
        snd(fr(0, 0, 29'h5A3, 8'hC4, 8'h3B), 1);
        snd(fr(0, 0, 29'h5A3, 8'hC4, 8'h00), 1);
        snd(fr(0, 0, 29'h5A3, 8'hC5, 8'h3B), 0);
        snd(fr(0, 1, 29'h5A3, 8'hC4, 8'h3B), 0);
        snd(fr(0, 0, 29'h5A2, 8'hC4, 8'h3B), 0);
        drain();
    endtask : t_sstd
    task automatic t_sext();
        cfg(2'h1, 32'h0, {29'h1ABCDE5, 1'b1, 2'h0}, 0);
        snd(fr(1, 1, 29'h1ABCDE5, 8'h11, 8'h22), 1);
        snd(fr(1, 0, 29'h1ABCDE5, 8'h11, 8'h22), 0);
        snd(fr(1, 1, 29'h1ABCDE4, 8'h11, 8'h22), 0);
        snd(fr(0, 1, 29'h00004E5, 8'h11, 8'h22), 0);
        drain();
    endtask : t_sext
    task automatic t_dstd();
        cfg(2'h2, 32'h0, {11'h123, 1'b0, 4'h9, 11'h456, 1'b0, 4'hC}, 0);
        snd(fr(0, 0, 29'h123, 8'h9C, 8'h00), 1);
        snd(fr(0, 0, 29'h123, 8'h9D, 8'h00), 0);
        snd(fr(0, 0, 29'h456, 8'h55, 8'h77), 1);
        snd(fr(0, 1, 29'h456, 8'h55, 8'h77), 0);
        snd(fr(0, 0, 29'h124, 8'h9C, 8'h00), 0);
        drain();
    endtask : t_dstd
    task automatic t_dext();
        cfg(2'h3, 32'h0, {16'h7878, 16'h91A2}, 0);
        snd(fr(1, 0, 29'h0F0F1FFF, 8'h01, 8'h02), 1);
        snd(fr(1, 0, 29'h12345AD2, 8'h01, 8'h02), 1);
        snd(fr(1, 0, 29'h0F0F2000, 8'h01, 8'h02), 0);
        snd(fr(0, 0, 29'h0F0F0000, 8'h01, 8'h02), 0);
        drain();
    endtask : t_dext
    // A write while running must leave mode and retry policy alone
    task automatic t_run();
        @(negedge mclk);
        {we, mode, sshot} = {1'b1, 2'h1, 1'b1};
        @(negedge mclk);
        we = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK(o_mode, 2'h3)
        `CHK(o_sshot, 1'h0)
    endtask : t_run
    // Two failures back to back, one answer each
    task automatic t_retry(input logic ss);
        cfg(2'h0, 32'hFFFFFFFF, 32'h0, ss);
        fail = 1'b1;
        repeat (2) begin
            @(negedge mclk);
            `CHK({retry, abort}, {~ss, ss})
        end
        fail = 1'b0;
        @(negedge mclk);
        `CHK({retry, abort}, 2'h0)
    endtask : t_retry
    // Consumer stalls; two entries fill and the source is refused
    task automatic t_buf();
        acc_ready = 1'b0;
        snd(fr(0, 0, 29'h001, 8'h10, 8'h20), 1);
        snd(fr(0, 1, 29'h002, 8'h30, 8'h40), 1);
        snd(fr(0, 0, 29'h003, 8'h50, 8'h60), 1);
        repeat (8) @(negedge mclk);
        `CHK({rx_ready, acc_valid, acc_id}, {2'h1, 29'h001})
        acc_ready = 1'b1;
        drain();
    endtask : t_buf

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        t_defaults();
        t_sstd();
        t_sext();
        t_dstd();
        t_dext();
        t_run();
        t_retry(1'b0);
        t_retry(1'b1);
        t_buf();
        tally_and_finish();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #(5000 * 8);
        num_errors++;
        tally_and_finish();
    end
endmodule : can_acceptance_filter_tb
`default_nettype wire
